// File: hdl/aidc_core.sv
// Command interpreter for idle, parameter, nop, buffer and DMA reads.
// Assumes host strobes synchronous to ref_clk and a media side that
// delivers words on a valid strobe.
//
// Functional notes
// - word 164 bits 2-0 give I/O cycle mode
// - word 164 bits 5-3 give memory cycle mode
// - bits 8-6 hold highest I/O UDMA mode
// - bits 11-9 hold highest memory UDMA mode
// - bits 14-12 hold selected UDMA mode
// - bit 15 validates the UDMA fields
// - idle: busy, idle, unbusy, interrupt
// - nonzero count arms power-down timer, count times 5 ms
// - zero count disables automatic power-down
// - no idle command: sleep after 20 ms
// - idle immediate keeps the power-down timer
// - 91h loads sectors per track and heads
// - NOP always ends with aborted error
// - read buffer presents buffer like PIO read
// - DMA read of 1-256 sectors, zero means 256
// - busy, fill, then hold DMAREQ while data
// - interrupt only at end or on error
// - address registers track last sector read
// - byte mode rejects DMA read with abort
// - PIO read: busy, load, DRQ, interrupt; read buffer here sets DRQ at once, with no busy or load
`timescale 1ns/1ns

module aidc_core #(
  parameter int SLEEP_CYCLES = aidc_pkg::SLEEP_CYC,
  parameter int UNIT_CYCLES = aidc_pkg::UNIT_CYC,
  parameter logic [2:0] IO_MODE = 3'h3,
  parameter logic [2:0] MEM_MODE = 3'h3,
  parameter logic [2:0] UIO_MAX = 3'h4,
  parameter logic [2:0] UMEM_MAX = 3'h4,
  parameter logic [2:0] USEL = 3'h4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Media side: sector words arriving into the buffer
  output logic media_req,
  output logic [27:0] media_lba,
  input wire logic media_valid,
  input wire logic [15:0] media_data,
  input wire logic media_error,
  // DMA handshake with host
  output logic dma_req,
  input wire logic dma_ack_n,
  input wire logic dma_rd_n,
  output logic [15:0] dma_data,
  // Host interrupt and power state
  output logic host_irq,
  output logic power_down,
  output logic sleep_mode
);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    AIDC_IDLE = 6'h01,    // Waiting for a command
    AIDC_FILL = 6'h02,    // Busy, loading a sector
    AIDC_PIO = 6'h04,     // DRQ set, host reading by PIO
    AIDC_DMA = 6'h08,     // DMAREQ held, host draining
    AIDC_DONE = 6'h10,    // Finish with interrupt
    AIDC_ABORT = 6'h20    // Finish with aborted error
  } aidc_state_t;

  aidc_state_t state_r, state_nxt;
  aidc_pkg::aidc_tf_t tf_r;       // Task-file registers
  logic [7:0] cmd_r;              // Command in progress
  logic [7:0] err_r;              // Error register
  logic err_flag_r;               // Status ERR bit
  logic [7:0] ctrl_r;             // Block control bits
  logic [7:0] spt_r;              // Sectors per track
  logic [3:0] heads_r;            // Heads minus one
  logic [15:0] buf_mem [0:255];   // One sector of words
  logic [7:0] wptr_r;             // Buffer fill pointer
  logic [7:0] rptr_r;             // Buffer drain pointer
  logic [8:0] secs_left_r;        // Sectors still to move
  logic [15:0] rdata_r;           // Read data register
  logic [15:0] dout_r;            // DMA data register
  logic irq_r;                    // Interrupt pending
  logic pd_en_r;                  // Auto power-down armed
  logic [7:0] pd_units_r;         // Power-down interval
  logic [7:0] pd_cnt_r;           // Elapsed 5 ms units
  logic [31:0] unit_cnt_r;        // Cycle count within a unit
  logic [31:0] sleep_cnt_r;       // Cycles since reset, held at the sleep limit or once idle is seen
  logic idle_seen_r;              // An idle command was issued
  logic pd_r;
  logic sleep_r;
  logic rd_n_d_r;                 // Last level of the read strobe
  logic buf_word_r;               // Reading from buffer by PIO

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire cmd_wr = reg_wr && (reg_addr == aidc_pkg::REG_STATUS);
  wire [7:0] cmd_in = reg_wdata[7:0];
  // busy covers the finishing cycle, dropped in the same cycle the interrupt is raised
  wire busy = (state_r == AIDC_FILL) || (state_r == AIDC_DONE) ||
              (state_r == AIDC_ABORT);
  wire is_idle = (cmd_in == aidc_pkg::CMD_IDLE_A) ||
                 (cmd_in == aidc_pkg::CMD_IDLE_B);
  wire is_idlei = (cmd_in == aidc_pkg::CMD_IDLEI_A) ||
                  (cmd_in == aidc_pkg::CMD_IDLEI_B);
  wire dma_cmd = (cmd_r == aidc_pkg::CMD_READ_DMA);
  wire unit_tick = (unit_cnt_r == 32'(UNIT_CYCLES - 1));
  wire data_rd = reg_rd && (reg_addr == aidc_pkg::REG_DATA);
  wire pio_take = (state_r == AIDC_PIO) && data_rd;
  // Falling edge of the read strobe while acknowledged
  wire dma_take = (state_r == AIDC_DMA) && !dma_ack_n &&
                  !dma_rd_n && rd_n_d_r;
  wire last_word = (rptr_r == 8'hFF);
  wire fill_done = media_valid && (wptr_r == 8'hFF);
  wire [27:0] lba = {tf_r.drv_hd[3:0], tf_r.cyl_hi, tf_r.cyl_lo,
                     tf_r.sec_num};

  wire [15:0] id164 = {1'b1, USEL, UMEM_MAX, UIO_MAX, MEM_MODE, IO_MODE};

  wire [7:0] status = {busy, !busy, 2'b00,
                       (state_r == AIDC_PIO), 2'b00, err_flag_r};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      AIDC_IDLE: begin
        // Commands arriving while busy are ignored elsewhere
        if (cmd_wr) begin
          if (cmd_in == aidc_pkg::CMD_NOP) begin
            state_nxt = AIDC_ABORT;
          end else if (cmd_in == aidc_pkg::CMD_READ_DMA) begin
            state_nxt = ctrl_r[aidc_pkg::CTRL_BYTE_MODE] ?
                        AIDC_ABORT : AIDC_FILL;
          end else if (cmd_in == aidc_pkg::CMD_READ_BUF) begin
            state_nxt = AIDC_PIO;
          end else if (is_idle || is_idlei ||
                       cmd_in == aidc_pkg::CMD_INIT_PARAM) begin
            state_nxt = AIDC_DONE;
          end else begin
            state_nxt = AIDC_ABORT;
          end
        end
      end
      AIDC_FILL: begin
        // stop on error at failing sector
        if (media_error) begin
          state_nxt = AIDC_ABORT;
        end else if (fill_done) begin
          state_nxt = AIDC_DMA;
        end
      end
      AIDC_PIO: begin
        if (pio_take && last_word) begin
          state_nxt = AIDC_DONE;
        end
      end
      AIDC_DMA: begin
        if (dma_take && last_word) begin
          state_nxt = (secs_left_r == 9'h001) ? AIDC_DONE : AIDC_FILL;
        end
      end
      AIDC_DONE: state_nxt = AIDC_IDLE;
      AIDC_ABORT: state_nxt = AIDC_IDLE;
      default: state_nxt = AIDC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= AIDC_IDLE;
      cmd_r <= 8'h00;
      err_r <= 8'h00;
      err_flag_r <= 1'b0;
      irq_r <= 1'b0;
      wptr_r <= 8'h00;
      rptr_r <= 8'h00;
      secs_left_r <= 9'h000;
      rd_n_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      rd_n_d_r <= dma_rd_n;
      // Status read acknowledges the interrupt
      if (reg_rd && reg_addr == aidc_pkg::REG_STATUS) begin
        irq_r <= 1'b0;
      end
      if (state_r == AIDC_IDLE && cmd_wr) begin
        cmd_r <= cmd_in;
        err_r <= 8'h00;
        err_flag_r <= 1'b0;
        wptr_r <= 8'h00;
        rptr_r <= 8'h00;
        secs_left_r <= (tf_r.sec_cnt == 8'h00) ? 9'h100 :
                       {1'b0, tf_r.sec_cnt};
      end
      if (state_r == AIDC_FILL && media_valid) begin
        wptr_r <= wptr_r + 8'h01;
      end
      if (pio_take || dma_take) begin
        rptr_r <= rptr_r + 8'h01;
      end
      if (dma_take && last_word) begin
        secs_left_r <= secs_left_r - 9'h001;
      end
      if (state_r == AIDC_DONE) begin
        irq_r <= 1'b1;
      end
      if (state_r == AIDC_ABORT) begin
        err_r <= aidc_pkg::ERR_ABORT;
        err_flag_r <= 1'b1;
        irq_r <= 1'b1;
      end
    end
  end

  // Sector buffer has no reset, contents are data only
  always_ff @(posedge ref_clk) begin
    if (state_r == AIDC_FILL && media_valid) begin
      buf_mem[wptr_r] <= media_data;
    end
  end

  // ----------------------------------------------------------------
  // Task file, control and geometry
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tf_r <= '0;
      ctrl_r <= 8'h00;
      spt_r <= 8'h00;
      heads_r <= 4'h0;
    end else begin
      // Task file is writable only while not busy
      if (reg_wr && !busy) begin
        unique case (reg_addr)
          aidc_pkg::REG_SEC_CNT: tf_r.sec_cnt <= reg_wdata[7:0];
          aidc_pkg::REG_SEC_NUM: tf_r.sec_num <= reg_wdata[7:0];
          aidc_pkg::REG_CYL_LO: tf_r.cyl_lo <= reg_wdata[7:0];
          aidc_pkg::REG_CYL_HI: tf_r.cyl_hi <= reg_wdata[7:0];
          aidc_pkg::REG_DRV_HD: tf_r.drv_hd <= reg_wdata[7:0];
          aidc_pkg::REG_CTRL: ctrl_r <= reg_wdata[7:0];
          default: ;
        endcase
      end
      // geometry from count and head nibble
      if (state_r == AIDC_IDLE && cmd_wr &&
          cmd_in == aidc_pkg::CMD_INIT_PARAM) begin
        spt_r <= tf_r.sec_cnt;
        heads_r <= tf_r.drv_hd[3:0];
      end
      if (dma_take && last_word && secs_left_r != 9'h001) begin
        {tf_r.drv_hd[3:0], tf_r.cyl_hi, tf_r.cyl_lo, tf_r.sec_num} <=
          lba + 28'h0000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power management timers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pd_en_r <= 1'b0;
      pd_units_r <= 8'h00;
      pd_cnt_r <= 8'h00;
      unit_cnt_r <= 32'h0;
      sleep_cnt_r <= 32'h0;
      idle_seen_r <= 1'b0;
      pd_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      unit_cnt_r <= unit_tick ? 32'h0 : unit_cnt_r + 32'h1;
      // Any command clears power-down; it clears sleep only once an earlier idle command has been seen
      if (cmd_wr && state_r == AIDC_IDLE) begin
        pd_r <= 1'b0;
        sleep_r <= 1'b0;
        pd_cnt_r <= 8'h00;
        // Restart the unit so the interval is counted from the command
        unit_cnt_r <= 32'h0;
      end
      if (state_r == AIDC_IDLE && cmd_wr && is_idle) begin
        idle_seen_r <= 1'b1;
        pd_en_r <= (tf_r.sec_cnt != 8'h00);
        pd_units_r <= tf_r.sec_cnt;
      end
      // idle immediate leaves timer as is
      if (pd_en_r && unit_tick && state_r == AIDC_IDLE && !pd_r) begin
        pd_cnt_r <= pd_cnt_r + 8'h01;
        if (pd_cnt_r + 8'h01 == pd_units_r) begin
          pd_r <= 1'b1;
        end
      end
      if (!idle_seen_r) begin
        if (sleep_cnt_r == 32'(SLEEP_CYCLES - 1)) begin
          sleep_r <= 1'b1;
        end else begin
          sleep_cnt_r <= sleep_cnt_r + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data paths
  // ----------------------------------------------------------------
  wire [15:0] rd_mux =
    (reg_addr == aidc_pkg::REG_DATA) ? buf_mem[rptr_r] :
    (reg_addr == aidc_pkg::REG_ERROR) ? {8'h00, err_r} :
    (reg_addr == aidc_pkg::REG_SEC_CNT) ? {8'h00, tf_r.sec_cnt} :
    (reg_addr == aidc_pkg::REG_SEC_NUM) ? {8'h00, tf_r.sec_num} :
    (reg_addr == aidc_pkg::REG_CYL_LO) ? {8'h00, tf_r.cyl_lo} :
    (reg_addr == aidc_pkg::REG_CYL_HI) ? {8'h00, tf_r.cyl_hi} :
    (reg_addr == aidc_pkg::REG_DRV_HD) ? {8'h00, tf_r.drv_hd} :
    (reg_addr == aidc_pkg::REG_STATUS) ? {8'h00, status} :
    (reg_addr == aidc_pkg::REG_CTRL) ? {8'h00, ctrl_r} :
    (reg_addr == aidc_pkg::REG_GEOM) ? {4'h0, heads_r, spt_r} :
    (reg_addr == aidc_pkg::REG_ID164) ? id164 : 16'h0000;

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
      dout_r <= 16'h0000;
      buf_word_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
      buf_word_r <= pio_take;
      if (dma_take) begin
        dout_r <= buf_mem[rptr_r];
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign dma_data = dout_r;
  assign dma_req = (state_r == AIDC_DMA) && dma_cmd;
  assign media_req = (state_r == AIDC_FILL);
  assign media_lba = lba;
  assign host_irq = irq_r;
  assign power_down = pd_r;
  assign sleep_mode = sleep_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  nop_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && cmd_in == aidc_pkg::CMD_NOP)
    |-> ##2 (err_r == aidc_pkg::ERR_ABORT && irq_r))
    else $error("nop did not abort");

  byte_mode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && ctrl_r[0] &&
     cmd_in == aidc_pkg::CMD_READ_DMA) |-> ##1 state_r == AIDC_ABORT)
    else $error("dma accepted in byte mode");

  idle_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && is_idle) |-> ##2 irq_r)
    else $error("idle gave no interrupt");

  idle_timer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && is_idle)
    |=> pd_en_r == ($past(tf_r.sec_cnt) != 8'h00))
    else $error("power-down arm wrong");

  idlei_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && is_idlei) |=> $stable(pd_en_r))
    else $error("idle immediate changed timer");

  geom_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_IDLE && cmd_wr && cmd_in == aidc_pkg::CMD_INIT_PARAM)
    |=> spt_r == $past(tf_r.sec_cnt))
    else $error("geometry not loaded");

  dma_noirq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == AIDC_DMA && !irq_r) |=> !irq_r)
    else $error("interrupt during dma");

  id_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == aidc_pkg::REG_ID164)
    |=> reg_rdata[15] && reg_rdata[2:0] == IO_MODE)
    else $error("capability word wrong");

endmodule

// File: shared/aidc_pkg.sv
// Shared constants and types for the ATA command interpreter block.
// Assumes one 250 MHz clock and a plain strobe register port.
package aidc_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_DATA = 4'h0;     // Data word, read side
  localparam logic [3:0] REG_ERROR = 4'h1;    // Error register, read side
  localparam logic [3:0] REG_SEC_CNT = 4'h2;  // Sector count
  localparam logic [3:0] REG_SEC_NUM = 4'h3;  // Sector number
  localparam logic [3:0] REG_CYL_LO = 4'h4;   // Cylinder low
  localparam logic [3:0] REG_CYL_HI = 4'h5;   // Cylinder high
  localparam logic [3:0] REG_DRV_HD = 4'h6;   // Drive/head select
  localparam logic [3:0] REG_STATUS = 4'h7;   // Status read, command write
  localparam logic [3:0] REG_CTRL = 4'h8;     // Block control bits
  localparam logic [3:0] REG_GEOM = 4'h9;     // Geometry readback
  localparam logic [3:0] REG_ID164 = 4'hA;    // Timing capability word

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE_A = 8'h97;
  localparam logic [7:0] CMD_IDLE_B = 8'hE3;
  localparam logic [7:0] CMD_IDLEI_A = 8'h95;
  localparam logic [7:0] CMD_IDLEI_B = 8'hE1;
  localparam logic [7:0] CMD_INIT_PARAM = 8'h91;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_READ_BUF = 8'hE4;
  localparam logic [7:0] CMD_READ_DMA = 8'hC8;

  // ----------------------------------------------------------------
  // Status and error bit positions
  // ----------------------------------------------------------------
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam int CTRL_BYTE_MODE = 0;
  localparam int DH_LBA = 6;

  // ----------------------------------------------------------------
  // Capability word fields
  // ----------------------------------------------------------------
  localparam int ID_IO_LO = 0;
  localparam int ID_MEM_LO = 3;
  localparam int ID_UIO_LO = 6;
  localparam int ID_UMEM_LO = 9;
  localparam int ID_USEL_LO = 12;
  localparam int ID_ADV = 15;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int IDLE_UNIT_MS = 5;
  localparam int SLEEP_MS = 20;
  localparam int UNIT_CYC = IDLE_UNIT_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_CYC = SLEEP_MS * 1000 * CLK_MHZ;
  localparam int WORDS_PER_SEC = 256;

  // Task-file registers, each written on its own register port address
  typedef struct packed {
    logic [7:0] drv_hd;
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic [7:0] sec_num;
    logic [7:0] sec_cnt;
  } aidc_tf_t;

endpackage

// File: testbench/aidc_dma_host.sv
// Host-side DMA reader model facing the command interpreter core.
// Assumes dma_req from the device and one clock shared with it.
`timescale 1ns/1ns

module aidc_dma_host (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [15:0] nwords,
  input wire logic [3:0] gap,
  input wire logic dma_req,
  output logic dma_ack_n,
  output logic dma_rd_n,
  input wire logic [15:0] dma_data,
  output logic [15:0] got_word,
  output logic [15:0] got_cnt,
  output logic stuck
);
  // ------------------------------------------------------------
  // Word reader
  // ------------------------------------------------------------
  // Strobe held low across the taking edge, data sampled a cycle
  // after release so the registered word has surely landed
  initial begin
    int w;
    dma_ack_n = 1'b1;
    dma_rd_n = 1'b1;
    got_word = 16'h0000;
    got_cnt = 16'h0000;
    stuck = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        for (int i = 0; i < int'(nwords); i++) begin
          // Bounded wait for data; a missing request is flagged
          w = 0;
          while (!dma_req && w < 4000) begin
            @(posedge ref_clk);
            w++;
          end
          if (w >= 4000) begin
            stuck <= 1'b1;
          end
          // ack then one strobe per word
          dma_ack_n <= 1'b0;
          dma_rd_n <= 1'b0;
          repeat (2) @(posedge ref_clk);
          dma_rd_n <= 1'b1;
          @(posedge ref_clk);
          got_word <= dma_data;
          got_cnt <= got_cnt + 16'h0001;
          // Optional stall to act as a slow host
          repeat (gap) @(posedge ref_clk);
        end
        // Transfer over: acknowledge released
        dma_ack_n <= 1'b1;
      end
    end
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the ATA command interpreter core.
// Assumes a media feeder here and the DMA host model beside the core.
`timescale 1ns/1ns

module tb_top;
  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  logic ref_clk, sys_rst, reg_wr, reg_rd, media_req, media_error;
  logic dma_req, dma_ack_n, dma_rd_n, host_irq, power_down, sleep_mode;
  logic dh_go, dh_stuck;
  logic media_valid = 1'b0;
  logic irq_q = 1'b0;
  logic [3:0] reg_addr;
  logic [3:0] dh_gap = 4'h1;
  logic [15:0] reg_wdata, reg_rdata, dma_data, got_word, got_cnt;
  logic [15:0] media_data = 16'h0000;
  logic [15:0] m_cnt = 16'h0000;
  logic [15:0] dh_words = 16'h0200;
  logic [27:0] media_lba;
  logic [31:0] d, irq_base;
  logic [31:0] irq_rises = 32'h0;
  logic [31:0] dma_idx = 32'h0;
  int err_total, tests_run;
  // Idle and idle-immediate opcodes, both spellings
  logic [7:0] codes [4] = '{aidc_pkg::CMD_IDLE_A, aidc_pkg::CMD_IDLE_B,
    aidc_pkg::CMD_IDLEI_A, aidc_pkg::CMD_IDLEI_B};

  // Short timer counts keep the run brief; memory and selected modes
  // keep their defaults so every capability field differs
  aidc_core #(.SLEEP_CYCLES(100), .UNIT_CYCLES(10), .IO_MODE(3'h1),
    .UIO_MAX(3'h5), .UMEM_MAX(3'h6))
  i_aidc_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .media_req(media_req), .media_lba(media_lba),
    .media_valid(media_valid), .media_data(media_data),
    .media_error(media_error), .dma_req(dma_req), .dma_ack_n(dma_ack_n),
    .dma_rd_n(dma_rd_n), .dma_data(dma_data), .host_irq(host_irq),
    .power_down(power_down), .sleep_mode(sleep_mode));

  aidc_dma_host i_aidc_dma_host (.ref_clk(ref_clk), .go(dh_go),
    .nwords(dh_words), .gap(dh_gap), .dma_req(dma_req),
    .dma_ack_n(dma_ack_n), .dma_rd_n(dma_rd_n), .dma_data(dma_data),
    .got_word(got_word), .got_cnt(got_cnt), .stuck(dh_stuck));

  // ------------------------------------------------------------
  // Clock, media feeder, monitors
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Media words count up, one every other cycle while filling
  always @(posedge ref_clk) begin
    irq_q <= host_irq;
    if (host_irq && !irq_q) irq_rises <= irq_rises + 32'h1;
    if (media_req && !media_valid) begin
      media_valid <= 1'b1;
      media_data <= m_cnt;
      m_cnt <= m_cnt + 16'h0001;
    end else begin
      media_valid <= 1'b0;
    end
  end

  // Every word the host model takes is compared in order
  always @(got_cnt) begin
    #1;
    if (got_cnt !== 16'h0000) begin
      check({16'h0000, got_word}, dma_idx);
      dma_idx = dma_idx + 32'h1;
    end
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= {8'h00, v};
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = {16'h0000, reg_rdata};
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (host_irq !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, dh_go, media_error} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    err_total = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(aidc_pkg::REG_ID164, d);
    check(d, 32'h0000CD59);
    check({31'h0, sleep_mode}, 32'h0);
    repeat (120) @(posedge ref_clk);
    check({31'h0, sleep_mode}, 32'h1);
    // Opcode 00 must abort
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_NOP);
    wait_irq();
    rd(aidc_pkg::REG_ERROR, d);
    check(d, 32'h00000004);
    rd(aidc_pkg::REG_STATUS, d);
    check(d & 32'h81, 32'h01);
    // Geometry load completes cleanly
    wr(aidc_pkg::REG_SEC_CNT, 8'h3F);
    wr(aidc_pkg::REG_DRV_HD, 8'hA5);
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_INIT_PARAM);
    wait_irq();
    rd(aidc_pkg::REG_STATUS, d);
    check(d & 32'h81, 32'h00);
    rd(aidc_pkg::REG_GEOM, d);
    check(d, 32'h0000053F);
    // Byte mode refuses the DMA read
    wr(aidc_pkg::REG_CTRL, 8'h01);
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_READ_DMA);
    wait_irq();
    rd(aidc_pkg::REG_ERROR, d);
    check(d, 32'h00000004);
    rd(aidc_pkg::REG_STATUS, d);
    wr(aidc_pkg::REG_CTRL, 8'h00);
    // two-sector DMA read from LBA 4302010
    wr(aidc_pkg::REG_SEC_NUM, 8'h10);
    wr(aidc_pkg::REG_CYL_LO, 8'h20);
    wr(aidc_pkg::REG_CYL_HI, 8'h30);
    wr(aidc_pkg::REG_DRV_HD, 8'hE4);
    wr(aidc_pkg::REG_SEC_CNT, 8'h02);
    irq_base = irq_rises;
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_READ_DMA);
    #1;
    check({4'h0, media_lba}, 32'h04302010);
    dh_go <= 1'b1;
    @(posedge ref_clk);
    dh_go <= 1'b0;
    for (int n = 0; n < 20000 && got_cnt !== 16'h0200; n++) begin
      @(posedge ref_clk);
    end
    if (got_cnt !== 16'h0200) begin
      err_total++;
      finish_test();
    end
    wait_irq();
    check(dma_idx, 32'h200);
    check(irq_rises - irq_base, 32'h1);
    rd(aidc_pkg::REG_SEC_NUM, d);
    check(d, 32'h11);
    rd(aidc_pkg::REG_STATUS, d);
    // Buffer readback holds the second sector
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_READ_BUF);
    rd(aidc_pkg::REG_STATUS, d);
    check(d & 32'h88, 32'h08);
    for (int i = 0; i < 256; i++) begin
      rd(aidc_pkg::REG_DATA, d);
      check(d, 32'h100 + i);
    end
    wait_irq();
    rd(aidc_pkg::REG_STATUS, d);
    // Media fault mid-fill: abort, address stays on the failing sector
    wr(aidc_pkg::REG_SEC_CNT, 8'h01);
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_READ_DMA);
    repeat (6) @(posedge ref_clk);
    media_error <= 1'b1;
    @(posedge ref_clk);
    media_error <= 1'b0;
    wait_irq();
    rd(aidc_pkg::REG_ERROR, d);
    check(d, 32'h00000004);
    rd(aidc_pkg::REG_SEC_NUM, d);
    check(d, 32'h11);
    rd(aidc_pkg::REG_STATUS, d);
    // Every idle opcode with a zero count
    foreach (codes[k]) begin
      wr(aidc_pkg::REG_SEC_CNT, 8'h00);
      wr(aidc_pkg::REG_STATUS, codes[k]);
      wait_irq();
      rd(aidc_pkg::REG_STATUS, d);
      check(d & 32'h81, 32'h00);
    end
    repeat (40) @(posedge ref_clk);
    check({31'h0, power_down}, 32'h0);
    // Two timer units arm power-down
    wr(aidc_pkg::REG_SEC_CNT, 8'h02);
    wr(aidc_pkg::REG_STATUS, aidc_pkg::CMD_IDLE_B);
    wait_irq();
    rd(aidc_pkg::REG_STATUS, d);
    repeat (8) @(posedge ref_clk);
    check({31'h0, power_down}, 32'h0);
    repeat (20) @(posedge ref_clk);
    check({31'h0, power_down}, 32'h1);
    check({31'h0, dh_stuck}, 32'h0);
    finish_test();
  end
endmodule
